// ==== rtl/adccc_pkg.sv ====
// constants for the converter control block
package adccc_pkg;
    // register byte addresses
    localparam logic [7:0] CTRL_A_ADDR   = 8'h00;
    localparam logic [7:0] CTRL_B_ADDR   = 8'h04;
    localparam logic [7:0] RES_LOW_ADDR  = 8'h08;
    localparam logic [7:0] RES_HIGH_ADDR = 8'h0c;
    localparam logic [7:0] PIN_SEL_ADDR  = 8'h10;
    localparam logic [7:0] INT_EN_ADDR   = 8'h14;
    localparam logic [7:0] INT_FLAG_ADDR = 8'h18;
    // control a field positions
    localparam int START_BIT  = 7;
    localparam int BUSY_BIT   = 6;
    localparam int PWR_BIT    = 5;
    localparam int DRIVE_BIT  = 4;
    localparam int CHSEL_BIT  = 0;
    // control b field positions
    localparam int SRC_LSB    = 5;
    localparam int REFSEL_BIT = 4;
    localparam int AMPV_BIT   = 3;
    localparam int DIV_LSB    = 0;
    // interrupt enable field positions
    localparam int GIE_BIT    = 0;
    localparam int CIE_BIT    = 1;
    // reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    // conversion timing in conversion clock cycles
    localparam int SAMPLE_CYC  = 4;
    localparam int CONVERT_CYC = 10;
    localparam int TOTAL_CYC   = SAMPLE_CYC + CONVERT_CYC;
    // input source codes
    localparam logic [1:0] SRC_EXT0   = 2'h0;
    localparam logic [1:0] SRC_BANDGAP = 2'h1;
    localparam logic [1:0] SRC_AMP    = 2'h2;
    localparam logic [1:0] SRC_EXT1   = 2'h3;
    // analog mux select codes driven out
    localparam logic [1:0] MUX_PIN0 = 2'h0;
    localparam logic [1:0] MUX_PIN1 = 2'h1;
    localparam logic [1:0] MUX_BG   = 2'h2;
    localparam logic [1:0] MUX_AMP  = 2'h3;
endpackage

// ==== rtl/adccc_top.sv ====
// converter control: AHB-Lite registers, divider, sequencer and result store
// Function
// - reference select picks supply or regulator
// - analog pin drops digital function and pullup
// - source codes 00/11 convert external channel
// - channel bit picks pin zero or one
// - 01 bandgap, 10 amplifier, channel ignored
// - start bit low-high-low pulse starts conversion
// - busy set once conversion starts
// - completion clears busy, sets request flag
// - interrupt needs global and converter enable
// - conversion clock is source over power two
// - converter powered only while enable high
// - 4 sample plus 10 convert cycles
// - disabling clears both result registers
// - result valid once busy is low
// - unsigned 10-bit code, full scale 3ff
// - result left aligned across two bytes
// - source clock from internal fast oscillator
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module adccc_top #(
    parameter int DW = 10
) (
    input  wire  logic          clk_i,
    input  wire  logic          srst_i,
    input  wire  logic          hsel_i,
    input  wire  logic [31:0]   haddr_i,
    input  wire  logic [1:0]    htrans_i,
    input  wire  logic          hwrite_i,
    input  wire  logic [2:0]    hsize_i,
    input  wire  logic [31:0]   hwdata_i,
    input  wire  logic          hready_i,
    output logic [31:0]         hrdata_o,
    output logic                hreadyout_o,
    output logic                hresp_o,
    input  wire  logic [DW-1:0] conv_data_i,
    output logic                conv_power_o,
    output logic                conv_sample_o,
    output logic                conv_clk_en_o,
    output logic [1:0]          input_mux_o,
    output logic                reference_select_o,
    output logic [1:0]          pin_analog_o,
    output logic                irq_o
);
    typedef enum logic [2:0] {
        ADCCC_IDLE   = 3'b001,
        ADCCC_SAMPLE = 3'b010,
        ADCCC_CONV   = 3'b100
    } adccc_state_t;

    logic [7:0]   ctrl_a_r;
    logic [7:0]   ctrl_b_r;
    logic [1:0]   pin_sel_r;
    logic [1:0]   int_en_r;
    logic         int_flag_r;
    logic [7:0]   res_high_r;
    logic [1:0]   res_low_r;
    logic         busy_r;
    adccc_state_t state_r;
    logic [3:0]   cyc_r;
    logic [6:0]   div_cnt_r;
    logic         tick_r;
    logic         start_prev_r;
    logic         wr_pend_r;
    logic [7:0]   wr_addr_r;
    logic         start_req;
    logic         done_ev;
    logic         wr_intflag;
    logic [6:0]   div_mask;

    // power of two divider mask from the 3-bit code
    function automatic logic [6:0] div_mask_f(input logic [2:0] code);
        div_mask_f = 7'((8'h01 << code) - 8'h01);
    endfunction

    // mux select from source field and channel bit
    function automatic logic [1:0] mux_f(input logic [1:0] src, input logic ch);
        unique case (src)
            adccc_pkg::SRC_BANDGAP: mux_f = adccc_pkg::MUX_BG;
            adccc_pkg::SRC_AMP:     mux_f = adccc_pkg::MUX_AMP;
            default:                mux_f = ch ? adccc_pkg::MUX_PIN1 : adccc_pkg::MUX_PIN0;
        endcase
    endfunction

    // AHB-Lite address phase capture, zero wait states
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (hready_i) begin
            wr_pend_r <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr_r <= haddr_i[7:0];
        end
    end

    // read data registered at the address phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i[7:0])
                adccc_pkg::CTRL_A_ADDR:   hrdata_o <= {24'h0, ctrl_a_r[7], busy_r, ctrl_a_r[5:4], 3'h0, ctrl_a_r[0]};
                adccc_pkg::CTRL_B_ADDR:   hrdata_o <= {24'h0, 1'b0, ctrl_b_r[6:0]};
                adccc_pkg::RES_LOW_ADDR:  hrdata_o <= {24'h0, res_low_r, 6'h00};
                adccc_pkg::RES_HIGH_ADDR: hrdata_o <= {24'h0, res_high_r};
                adccc_pkg::PIN_SEL_ADDR:  hrdata_o <= {30'h0, pin_sel_r};
                adccc_pkg::INT_EN_ADDR:   hrdata_o <= {30'h0, int_en_r};
                adccc_pkg::INT_FLAG_ADDR: hrdata_o <= {31'h0, int_flag_r};
                default:                  hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // always ready, always OKAY
    always_ff @(posedge clk_i) begin
        hreadyout_o <= 1'b1;
        hresp_o     <= 1'b0;
    end

    // control registers written in the data phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_a_r  <= adccc_pkg::CTRL_A_RST;
            ctrl_b_r  <= adccc_pkg::CTRL_B_RST;
            pin_sel_r <= 2'h0;
            int_en_r  <= 2'h0;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                adccc_pkg::CTRL_A_ADDR:  ctrl_a_r  <= hwdata_i[7:0] & 8'hb1;
                adccc_pkg::CTRL_B_ADDR:  ctrl_b_r  <= hwdata_i[7:0] & 8'h7f;
                adccc_pkg::PIN_SEL_ADDR: pin_sel_r <= hwdata_i[1:0];
                adccc_pkg::INT_EN_ADDR:  int_en_r  <= hwdata_i[1:0];
                default: ;
            endcase
        end
    end

    assign wr_intflag = wr_pend_r && (wr_addr_r == adccc_pkg::INT_FLAG_ADDR) && hwdata_i[0];

    // falling edge of start bit, only when powered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            start_prev_r <= 1'b0;
        end else begin
            // a high level written while off must not arm a start later
            start_prev_r <= ctrl_a_r[adccc_pkg::START_BIT] && ctrl_a_r[adccc_pkg::PWR_BIT];
        end
    end
    assign start_req = start_prev_r && !ctrl_a_r[adccc_pkg::START_BIT]
                       && ctrl_a_r[adccc_pkg::PWR_BIT] && !busy_r;

    // clk_i is the internal fast oscillator
    assign div_mask = div_mask_f(ctrl_b_r[adccc_pkg::DIV_LSB +: 3]);
    always_ff @(posedge clk_i) begin
        if (srst_i || start_req) begin
            // restart so the first tick is a whole period after start
            div_cnt_r <= 7'h00;
            tick_r    <= 1'b0;
        end else begin
            tick_r    <= (div_cnt_r & div_mask) == div_mask;
            div_cnt_r <= ((div_cnt_r & div_mask) == div_mask) ? 7'h00 : 7'(div_cnt_r + 7'h01);
        end
    end

    // 4 sample then 10 convert clock cycles
    always_ff @(posedge clk_i) begin
        if (srst_i || !ctrl_a_r[adccc_pkg::PWR_BIT]) begin
            state_r <= ADCCC_IDLE;
            cyc_r   <= 4'h0;
        end else begin
            unique case (state_r)
                ADCCC_IDLE: begin
                    if (start_req) begin
                        state_r <= ADCCC_SAMPLE;
                        cyc_r   <= 4'h0;
                    end
                end
                ADCCC_SAMPLE: begin
                    if (tick_r) begin
                        cyc_r <= 4'(cyc_r + 4'h1);
                        if (cyc_r == 4'(adccc_pkg::SAMPLE_CYC - 1)) begin
                            state_r <= ADCCC_CONV;
                        end
                    end
                end
                ADCCC_CONV: begin
                    if (tick_r) begin
                        cyc_r <= 4'(cyc_r + 4'h1);
                        if (cyc_r == 4'(adccc_pkg::TOTAL_CYC - 1)) begin
                            state_r <= ADCCC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign done_ev = (state_r == ADCCC_CONV) && tick_r && (cyc_r == 4'(adccc_pkg::TOTAL_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (srst_i || !ctrl_a_r[adccc_pkg::PWR_BIT]) begin
            busy_r <= 1'b0;
        end else if (start_req) begin
            busy_r <= 1'b1;
        end else if (done_ev) begin
            busy_r <= 1'b0;
        end
    end

    // request flag set on completion, set beats clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            int_flag_r <= 1'b0;
        end else if (done_ev) begin
            int_flag_r <= 1'b1;
        end else if (wr_intflag) begin
            int_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !ctrl_a_r[adccc_pkg::PWR_BIT]) begin
            // power off aborts and empties the result pair
            res_high_r <= 8'h00;
            res_low_r  <= 2'h0;
        end else if (done_ev) begin
            res_high_r <= conv_data_i[DW-1:DW-8];
            res_low_r  <= conv_data_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_power_o <= 1'b0;
        end else begin
            conv_power_o <= ctrl_a_r[adccc_pkg::PWR_BIT];
        end
    end

    // sampling window strobe to the analog side
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_sample_o <= 1'b0;
        end else begin
            conv_sample_o <= state_r == ADCCC_SAMPLE;
        end
    end

    // one conversion clock strobe per tick while sampling or converting
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_clk_en_o <= 1'b0;
        end else begin
            conv_clk_en_o <= tick_r && (state_r != ADCCC_IDLE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            input_mux_o <= adccc_pkg::MUX_PIN0;
        end else begin
            input_mux_o <= mux_f(ctrl_b_r[adccc_pkg::SRC_LSB +: 2], ctrl_a_r[adccc_pkg::CHSEL_BIT]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reference_select_o <= 1'b0;
        end else begin
            reference_select_o <= ctrl_b_r[adccc_pkg::REFSEL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_analog_o <= 2'h0;
        end else begin
            pin_analog_o <= pin_sel_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= int_flag_r && int_en_r[adccc_pkg::GIE_BIT] && int_en_r[adccc_pkg::CIE_BIT];
        end
    end
endmodule
`default_nettype wire

// ==== verif/adccc_sva.sv ====
// port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adccc_sva #(
    parameter int DW = 10
) (
    input wire logic          clk_i,
    input wire logic          srst_i,
    input wire logic          hsel_i,
    input wire logic [31:0]   haddr_i,
    input wire logic [1:0]    htrans_i,
    input wire logic          hwrite_i,
    input wire logic [2:0]    hsize_i,
    input wire logic [31:0]   hwdata_i,
    input wire logic          hready_i,
    input wire logic [31:0]   hrdata_o,
    input wire logic          hreadyout_o,
    input wire logic          hresp_o,
    input wire logic [DW-1:0] conv_data_i,
    input wire logic          conv_power_o,
    input wire logic          conv_sample_o,
    input wire logic          conv_clk_en_o,
    input wire logic [1:0]    input_mux_o,
    input wire logic          reference_select_o,
    input wire logic [1:0]    pin_analog_o,
    input wire logic          irq_o
);
    logic       wv;
    logic [7:0] wa;
    logic [7:0] sa;
    logic [7:0] sb;
    logic [7:0] sp;
    logic [7:0] si;
    logic [4:0] tk;
    logic [1:0] xm;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // shadow copies of written registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wv <= 1'b0;
            wa <= 8'h00;
            sa <= 8'h00;
            sb <= 8'h00;
            sp <= 8'h00;
            si <= 8'h00;
        end else begin
            wv <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
            wa <= haddr_i[7:0];
            if (wv && wa == adccc_pkg::CTRL_A_ADDR) sa <= hwdata_i[7:0];
            if (wv && wa == adccc_pkg::CTRL_B_ADDR) sb <= hwdata_i[7:0];
            if (wv && wa == adccc_pkg::PIN_SEL_ADDR) sp <= hwdata_i[7:0];
            if (wv && wa == adccc_pkg::INT_EN_ADDR) si <= hwdata_i[7:0];
        end
    end
    // conversion clock ticks since sampling began
    always_ff @(posedge clk_i) begin
        if (srst_i) tk <= 5'h00;
        else if ($rose(conv_sample_o)) tk <= {4'h0, conv_clk_en_o};
        else if (conv_clk_en_o) tk <= tk + 5'h01;
    end
    // expected analog select from the shadows
    assign xm = (sb[6:5] == adccc_pkg::SRC_BANDGAP) ? adccc_pkg::MUX_BG :
                (sb[6:5] == adccc_pkg::SRC_AMP) ? adccc_pkg::MUX_AMP : {1'b0, sa[0]};
    property p_ready; hreadyout_o && !hresp_o; endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_mux; $stable(sa) && $stable(sb) |-> input_mux_o == xm; endproperty
    a_mux: assert property (p_mux) else $error("wrong analog select");
    property p_ref; $stable(sb) |-> reference_select_o == sb[4]; endproperty
    a_ref: assert property (p_ref) else $error("wrong reference");
    property p_pin; $stable(sp) |-> pin_analog_o == sp[1:0]; endproperty
    a_pin: assert property (p_pin) else $error("wrong pin mode");
    property p_pwr; $stable(sa) |-> conv_power_o == sa[5]; endproperty
    a_pwr: assert property (p_pwr) else $error("power not following enable");
    property p_off; !conv_power_o && !$past(conv_power_o) |-> !conv_sample_o && !conv_clk_en_o; endproperty
    a_off: assert property (p_off) else $error("activity while off");
    property p_samp; $fell(conv_sample_o) && conv_power_o |-> ##[0:1] tk == 5'd4; endproperty
    a_samp: assert property (p_samp) else $error("sampling length wrong");
    property p_end; $rose(irq_o) |-> ##[0:2] tk == 5'd14; endproperty
    a_end: assert property (p_end) else $error("request not at tick 14");
    property p_irq; irq_o && $stable(si) |-> si[1:0] == 2'h3; endproperty
    a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule
bind adccc_top adccc_sva #(.DW(DW)) u_sva (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .conv_data_i(conv_data_i), .conv_power_o(conv_power_o), .conv_sample_o(conv_sample_o),
    .conv_clk_en_o(conv_clk_en_o), .input_mux_o(input_mux_o), .reference_select_o(reference_select_o),
    .pin_analog_o(pin_analog_o), .irq_o(irq_o));
`default_nettype wire

// ==== verif/adc_conversion_control_bench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [9:0]  conv_data_i = 10'h000;
    logic [31:0] hrdata_o;
    logic [31:0] rdat;
    logic        hreadyout_o;
    logic        hresp_o;
    logic        conv_power_o;
    logic        conv_sample_o;
    logic        conv_clk_en_o;
    logic        reference_select_o;
    logic        irq_o;
    logic [1:0]  input_mux_o;
    logic [1:0]  pin_analog_o;
    logic [1:0]  pin_exp;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          ticks = 0;
    time         t0;
    time         t1;
    always #12.5 clk_i = ~clk_i;
    adccc_top dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .conv_data_i(conv_data_i), .conv_power_o(conv_power_o),
        .conv_sample_o(conv_sample_o), .conv_clk_en_o(conv_clk_en_o), .input_mux_o(input_mux_o),
        .reference_select_o(reference_select_o), .pin_analog_o(pin_analog_o), .irq_o(irq_o));
    // count conversion clock ticks and note first and last
    always @(posedge clk_i) begin
        if (conv_clk_en_o === 1'b1) begin
            if (ticks == 0) t0 = $time;
            ticks++;
            t1 = $time;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // address phase then data phase, each held until ready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= 2'h2;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        rdat = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 8'h00);
    endtask
    // one conversion at divider code c with a restart attempt while busy
    task automatic conv(input int c);
        logic [9:0] v;
        v = (c == 7) ? 10'h3ff : {c[2:0], 7'h55};
        conv_data_i <= v;
        wr(adccc_pkg::INT_EN_ADDR, (c == 0) ? 8'h02 : (c == 1) ? 8'h01 : 8'h03);
        wr(adccc_pkg::CTRL_B_ADDR, {5'h0, c[2:0]});
        ticks = 0;
        wr(adccc_pkg::CTRL_A_ADDR, 8'ha0);
        wr(adccc_pkg::CTRL_A_ADDR, 8'h20);
        wr(adccc_pkg::CTRL_A_ADDR, 8'ha0);
        wr(adccc_pkg::CTRL_A_ADDR, 8'h20);
        rd(adccc_pkg::CTRL_A_ADDR);
        chk(rdat[6], 1);
        for (int i = 0; i < 2000 && rdat[6] !== 1'b0; i++) rd(adccc_pkg::CTRL_A_ADDR);
        chk(rdat[6], 0);
        chk(ticks, 14);
        chk(32'(t1 - t0), 13 * (25 << c));
        rd(adccc_pkg::RES_HIGH_ADDR);
        chk(rdat, {24'h0, v[9:2]});
        rd(adccc_pkg::RES_LOW_ADDR);
        chk(rdat, {24'h0, v[1:0], 6'h0});
        chk(irq_o, c > 1);
        rd(adccc_pkg::INT_FLAG_ADDR);
        chk(rdat, 1);
        wr(adccc_pkg::INT_FLAG_ADDR, 8'h01);
        rd(adccc_pkg::INT_FLAG_ADDR);
        chk(rdat, 0);
        chk(irq_o, 0);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #1500000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(adccc_pkg::CTRL_A_ADDR);
        chk(rdat, {24'h0, adccc_pkg::CTRL_A_RST});
        rd(adccc_pkg::CTRL_B_ADDR);
        chk(rdat, {24'h0, adccc_pkg::CTRL_B_RST});
        wr(8'h1c, 8'hff);
        rd(8'h1c);
        chk(rdat, 0);
        // every source code with both channels and references
        for (int s = 0; s < 4; s++) begin
            for (int ch = 0; ch < 2; ch++) begin
                wr(adccc_pkg::CTRL_B_ADDR, {1'b0, s[1:0], ch[0], 4'h0});
                wr(adccc_pkg::CTRL_A_ADDR, {7'h0, ch[0]});
                // no pin goes analog while an internal source is selected
                pin_exp = (s == 1 || s == 2) ? 2'h0 : (s == 3) ? 2'h3 : (ch == 1) ? 2'h2 : 2'h1;
                wr(adccc_pkg::PIN_SEL_ADDR, {6'h0, pin_exp});
                repeat (2) @(posedge clk_i);
                chk(input_mux_o, (s == 1) ? 2 : (s == 2) ? 3 : ch);
                chk(reference_select_o, ch);
                chk(pin_analog_o, pin_exp);
            end
        end
        wr(adccc_pkg::CTRL_A_ADDR, 8'h20);
        repeat (20) @(posedge clk_i);
        chk(conv_power_o, 1);
        // the data model ignores clock period, so every code checks divider timing, result bytes and request flag
        for (int c = 0; c < 8; c++) conv(c);
        wr(adccc_pkg::CTRL_A_ADDR, 8'h00);
        @(posedge clk_i); // results empty one edge after the write
        rd(adccc_pkg::RES_HIGH_ADDR);
        chk(rdat, 0);
        rd(adccc_pkg::RES_LOW_ADDR);
        chk(rdat, 0);
        ticks = 0;
        wr(adccc_pkg::CTRL_A_ADDR, 8'h80);
        wr(adccc_pkg::CTRL_A_ADDR, 8'h00);
        repeat (4) @(posedge clk_i);
        rd(adccc_pkg::CTRL_A_ADDR);
        chk(rdat, 0);
        chk(ticks, 0);
        // start raised while off, dropped as power comes on
        wr(adccc_pkg::CTRL_A_ADDR, 8'h80);
        wr(adccc_pkg::CTRL_A_ADDR, 8'h20);
        repeat (4) @(posedge clk_i);
        rd(adccc_pkg::CTRL_A_ADDR);
        chk(rdat, 32'h20);
        chk(ticks, 0);
        print_verdict;
    end
endmodule
`default_nettype wire
